//--- verilog/iso_exec.sv
// Purpose: execute increment-skip, or-literal, load-literal and or-register
// Assumes: insn_valid_in marks a fetched word; reg_rdata_in is the register at reg_addr_out
//          combinationally in the same cycle (register file lives outside)
// Notes:   all results are registered; the skip turns the next valid word into a no-op
module iso_exec
   import iso_pkg::*;
(
   input  wire logic                  core_clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  insn_valid_in,
   input  wire logic [ISO_INSN_W-1:0] insn_in,
   output logic      [ISO_ADDR_W-1:0] reg_addr_out,
   input  wire logic [ISO_DATA_W-1:0] reg_rdata_in,
   output logic                       reg_we_out,
   output logic      [ISO_ADDR_W-1:0] reg_waddr_out,
   output logic      [ISO_DATA_W-1:0] reg_wdata_out,
   output logic      [ISO_DATA_W-1:0] acc_out,
   output logic                       zero_flag_out,
   output logic                       skip_out,
   output logic                       done_out
);
   iso_op_t                 op;
   logic                    skip_reg,  skip_next;
   logic [ISO_DATA_W-1:0]   acc_reg,   acc_next;
   logic                    zf_reg,    zf_next;
   logic                    we_reg,    we_next;
   logic [ISO_ADDR_W-1:0]   wa_reg,    wa_next;
   logic [ISO_DATA_W-1:0]   wd_reg,    wd_next;
   logic                    done_reg,  done_next;
   logic [ISO_DATA_W-1:0]   result;
   logic                    dest_reg_sel;
   logic                    live;

   // is_zero serves the execute logic; uses_register is shared with its checks
   function automatic logic is_zero(input logic [ISO_DATA_W-1:0] value);
      return value == ISO_ZERO;
   endfunction : is_zero

   function automatic logic uses_register(input iso_op_t kind);
      return kind == ISO_INCREMENT_SKIP_IF_ZERO || kind == ISO_OR_ACCUMULATOR_WITH_REGISTER;
   endfunction : uses_register

   ////////////////////////////////////////////////////////////////////////////
   iso_decode u_dec (
      .insn_in (insn_in),
      .op_out  (op)
   );

   // read address stays combinational so the register file answers in the taking cycle
   always_comb begin
      reg_addr_out = insn_in[ISO_ADDR_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      live         = insn_valid_in && !skip_reg;
      dest_reg_sel = insn_in[ISO_DEST_BIT];
      acc_next     = acc_reg;
      zf_next      = zf_reg;
      we_next      = 1'b0;
      wa_next      = wa_reg;
      wd_next      = wd_reg;
      done_next    = 1'b0;
      skip_next    = skip_reg;
      result       = ISO_ZERO;
      if (insn_valid_in && skip_reg) begin
         // discarded prefetched word runs as a no-op
         skip_next = 1'b0;
         done_next = 1'b1;
      end else if (live) begin
         done_next = 1'b1;
         case (op)
            ISO_INCREMENT_SKIP_IF_ZERO: begin
               result    = reg_rdata_in + ISO_ONE;
               skip_next = is_zero(result);
            end
            ISO_OR_ACCUMULATOR_WITH_REGISTER: begin
               result  = acc_reg | reg_rdata_in;
               zf_next = is_zero(result);
            end
            ISO_OR_LITERAL_TO_ACCUMULATOR: begin
               result   = acc_reg | insn_in[ISO_DATA_W-1:0];
               zf_next  = is_zero(result);
               acc_next = result;
            end
            ISO_LOAD_LITERAL_TO_ACCUMULATOR: begin
               acc_next = insn_in[ISO_DATA_W-1:0];
            end
            default: begin
               done_next = 1'b0;
            end
         endcase
         if (uses_register(op)) begin
            if (dest_reg_sel) begin
               we_next = 1'b1;
               wa_next = insn_in[ISO_ADDR_W-1:0];
               wd_next = result;
            end else begin
               acc_next = result;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         acc_reg  <= ISO_ZERO;
         zf_reg   <= 1'b0;
         we_reg   <= 1'b0;
         wa_reg   <= '0;
         wd_reg   <= ISO_ZERO;
         done_reg <= 1'b0;
         skip_reg <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         zf_reg   <= zf_next;
         we_reg   <= we_next;
         wa_reg   <= wa_next;
         wd_reg   <= wd_next;
         done_reg <= done_next;
         skip_reg <= skip_next;
      end
   end

   always_comb begin
      acc_out       = acc_reg;
      zero_flag_out = zf_reg;
      reg_we_out    = we_reg;
      reg_waddr_out = wa_reg;
      reg_wdata_out = wd_reg;
      skip_out      = skip_reg;
      done_out      = done_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_inc_zero;
      live && op == ISO_INCREMENT_SKIP_IF_ZERO && reg_rdata_in == 8'hff;
   endsequence

   sequence s_skip_consume;
      skip_out && insn_valid_in;
   endsequence

   sequence s_skip_pending;
      skip_out && !insn_valid_in;
   endsequence

   property p_inc_value;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_INCREMENT_SKIP_IF_ZERO && dest_reg_sel |=>
         reg_we_out && reg_wdata_out == $past(reg_rdata_in) + 8'h01;
   endproperty
   a_inc_value: assert property (p_inc_value) else $error("increment value wrong");

   property p_inc_acc;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_INCREMENT_SKIP_IF_ZERO && !dest_reg_sel |=>
         !reg_we_out && acc_out == $past(reg_rdata_in) + 8'h01;
   endproperty
   a_inc_acc: assert property (p_inc_acc) else $error("increment into accumulator wrong");

   property p_inc_flags;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_INCREMENT_SKIP_IF_ZERO |=> $stable(zero_flag_out);
   endproperty
   a_inc_flags: assert property (p_inc_flags) else $error("increment touched flag");

   property p_dest_acc;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_OR_ACCUMULATOR_WITH_REGISTER && !dest_reg_sel |=>
         !reg_we_out && acc_out == ($past(acc_reg) | $past(reg_rdata_in));
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong");

   property p_dest_reg;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && dest_reg_sel && uses_register(op) |=>
         reg_we_out && reg_waddr_out == $past(reg_addr_out) && $stable(acc_out);
   endproperty
   a_dest_reg: assert property (p_dest_reg) else $error("register destination wrong");

   property p_skip;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_inc_zero |=> skip_out;
   endproperty
   a_skip: assert property (p_skip) else $error("skip not taken");

   property p_skip_nop;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_skip_consume |=> !skip_out && done_out && !reg_we_out &&
         $stable(acc_out) && $stable(zero_flag_out);
   endproperty
   a_skip_nop: assert property (p_skip_nop) else $error("discarded word not a no-op");

   property p_skip_hold;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_skip_pending |=> skip_out && !done_out;
   endproperty
   a_skip_hold: assert property (p_skip_hold) else $error("pending skip lost");

   property p_no_skip;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_INCREMENT_SKIP_IF_ZERO && reg_rdata_in != 8'hff |=> !skip_out;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("skip taken wrongly");

   property p_orlit;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_OR_LITERAL_TO_ACCUMULATOR |=> done_out &&
         acc_out == ($past(acc_reg) | $past(insn_in[7:0])) && zero_flag_out == (acc_out == 8'h00);
   endproperty
   a_orlit: assert property (p_orlit) else $error("or literal wrong");

   property p_orreg_zf;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_OR_ACCUMULATOR_WITH_REGISTER |=>
         done_out && zero_flag_out == (($past(acc_reg) | $past(reg_rdata_in)) == 8'h00);
   endproperty
   a_orreg_zf: assert property (p_orreg_zf) else $error("or register zero flag wrong");

   property p_ldlit;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      live && op == ISO_LOAD_LITERAL_TO_ACCUMULATOR |=>
         acc_out == $past(insn_in[7:0]) && $stable(zero_flag_out) && !reg_we_out;
   endproperty
   a_ldlit: assert property (p_ldlit) else $error("load literal wrong");
endmodule : iso_exec

//--- verilog/iso_pkg.sv
// Purpose: constants for the increment-skip / or / load-literal execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit register addresses
// Notes:   shared by the execute top and its operation decoder
//
// Functional notes
// - increment-skip opcode adds one to register f, writes destination, flags unchanged.
// - destination bit clear sends the result to the accumulator, register untouched.
// - destination bit set writes the result back into the source register.
// - zero increment result discards prefetched instruction, runs a no-op, two cycles.
// - or-literal opcode ORs accumulator with literal, writes accumulator, updates zero flag.
// - or-register opcode ORs accumulator with register, selected destination, updates zero.
package iso_pkg;
   localparam int          ISO_INSN_W    = 14;
   localparam int          ISO_DATA_W    = 8;
   localparam int          ISO_ADDR_W    = 7;
   localparam int          ISO_DEST_BIT  = 7;
   localparam logic [5:0]  ISO_OP_INCSKIP = 6'h0f;
   localparam logic [5:0]  ISO_OP_ORREG   = 6'h04;
   localparam logic [5:0]  ISO_OP_ORLIT   = 6'h38;
   localparam logic [3:0]  ISO_OP_LDLIT   = 4'hc;
   localparam logic [7:0]  ISO_ONE        = 8'h01;
   localparam logic [7:0]  ISO_ZERO       = 8'h00;
   localparam logic [13:0] ISO_NOP        = 14'h0000;

   typedef enum {
      ISO_NONE,
      ISO_INCREMENT_SKIP_IF_ZERO,
      ISO_OR_LITERAL_TO_ACCUMULATOR,
      ISO_LOAD_LITERAL_TO_ACCUMULATOR,
      ISO_OR_ACCUMULATOR_WITH_REGISTER
   } iso_op_t;
endpackage : iso_pkg

//--- verilog/iso_decode.sv
// Purpose: classify an instruction word into one of the handled operations
// Assumes: purely combinational
// Notes:   anything else decodes to none
module iso_decode
   import iso_pkg::*;
(
   input  wire logic [ISO_INSN_W-1:0] insn_in,
   output iso_op_t                    op_out
);
   always_comb begin
      op_out = ISO_NONE;
      if (insn_in[13:8] == ISO_OP_INCSKIP) begin
         op_out = ISO_INCREMENT_SKIP_IF_ZERO;
      end else if (insn_in[13:8] == ISO_OP_ORREG) begin
         op_out = ISO_OR_ACCUMULATOR_WITH_REGISTER;
      end else if (insn_in[13:8] == ISO_OP_ORLIT) begin
         op_out = ISO_OR_LITERAL_TO_ACCUMULATOR;
      end else if (insn_in[13:10] == ISO_OP_LDLIT) begin
         op_out = ISO_LOAD_LITERAL_TO_ACCUMULATOR;
      end
   end
endmodule : iso_decode

//--- bench/iso_regfile_model.sv
// Purpose: data register file behind the execute block, read combinationally
// Assumes: one write port driven by the block's write strobe
// Notes:   0x7e and 0x7f preload to ff so an increment wraps to zero
module iso_regfile_model (
   input  wire logic       clk_in,
   input  wire logic [6:0] raddr_in,
   output logic      [7:0] rdata_out,
   input  wire logic       we_in,
   input  wire logic [6:0] waddr_in,
   input  wire logic [7:0] wdata_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [128];
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i);
      end
      mem[126] = 8'hff;
      mem[127] = 8'hff;
   end
   assign rdata_out = mem[raddr_in];
   always @(posedge clk_in) begin
      if (we_in === 1'b1) begin
         mem[waddr_in] <= wdata_in;
      end
   end
endmodule : iso_regfile_model

//--- bench/incskip_or_literal_exec_bench.sv
// Purpose: self-checking bench for the execute block
// Assumes: results appear just after the taking edge
// Notes:   table rows carry machine state forward, order matters
module incskip_or_literal_exec_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [13:0] insn;
      logic [7:0]  acc;
      logic        zero;
      logic        we;
      logic [7:0]  wdata;
   } iso_row_t;
   logic        clk, rst, valid, we, zf, skip, done;
   logic [13:0] insn;
   logic [6:0]  raddr, waddr;
   logic [7:0]  rdata, wdata, acc;
   int          err_total, check_count;
   iso_row_t    rows [13] = '{
      '{14'h305a, 8'h5a, 1'b0, 1'b0, 8'h00}, '{14'h3300, 8'h00, 1'b0, 1'b0, 8'h00},
      '{14'h3800, 8'h00, 1'b1, 1'b0, 8'h00}, '{14'h319a, 8'h9a, 1'b1, 1'b0, 8'h00},
      '{14'h3835, 8'hbf, 1'b0, 1'b0, 8'h00}, '{14'h0f10, 8'h11, 1'b0, 1'b0, 8'h00},
      '{14'h0fa0, 8'h11, 1'b0, 1'b1, 8'h21}, '{14'h3091, 8'h91, 1'b0, 1'b0, 8'h00},
      '{14'h0413, 8'h93, 1'b0, 1'b0, 8'h00}, '{14'h04a0, 8'h93, 1'b0, 1'b1, 8'hb3},
      '{14'h3000, 8'h00, 1'b0, 1'b0, 8'h00}, '{14'h0400, 8'h00, 1'b1, 1'b0, 8'h00},
      '{14'h0fa0, 8'h00, 1'b1, 1'b1, 8'hb4}};
   iso_exec dut (.core_clk_in(clk), .sys_rst_in(rst), .insn_valid_in(valid), .insn_in(insn),
      .reg_addr_out(raddr), .reg_rdata_in(rdata), .reg_we_out(we), .reg_waddr_out(waddr),
      .reg_wdata_out(wdata), .acc_out(acc), .zero_flag_out(zf), .skip_out(skip),
      .done_out(done));
   iso_regfile_model regs (.clk_in(clk), .raddr_in(raddr), .rdata_out(rdata), .we_in(we),
      .waddr_in(waddr), .wdata_in(wdata));
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic issue(input logic [13:0] w);
      @(posedge clk);
      valid <= 1'b1;
      insn  <= w;
      @(posedge clk);
      valid <= 1'b0;
      #1;
   endtask : issue
   task automatic complete_run;
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      err_total++;
      complete_run();
   end
   initial begin
      clk = 1'b0; rst = 1'b1; valid = 1'b0; insn = 14'h0000; err_total = 0; check_count = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check(acc, 8'h00);
      check({we, skip, zf, done, 4'h0}, 8'h00);
      foreach (rows[i]) begin
         issue(rows[i].insn);
         check(acc, rows[i].acc);
         check(8'(zf), 8'(rows[i].zero));
         check(8'(we), 8'(rows[i].we));
         check(8'(done), 8'h01);
         if (rows[i].we === 1'b1) begin
            check(wdata, rows[i].wdata);
            check(8'(waddr), 8'(rows[i].insn[6:0]));
         end
      end
      // wrap to zero with the next word back to back
      @(posedge clk);
      valid <= 1'b1;
      insn  <= 14'h0fff;
      @(posedge clk);
      insn  <= 14'h3055;
      #1;
      check({we, skip, done, 5'h00}, 8'he0);
      check(wdata, 8'h00);
      @(posedge clk);
      valid <= 1'b0;
      #1;
      check({we, skip, done, 5'h00}, 8'h20);
      check(acc, 8'h00);
      // wrap into the accumulator, then idle while the skip waits
      issue(14'h3055);
      check(acc, 8'h55);
      issue(14'h0f7e);
      check({we, skip, zf, 5'h00}, 8'h60);
      check(acc, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      check(8'(skip), 8'h01);
      issue(14'h38ff);
      check({skip, done, 6'h00}, 8'h40);
      check(acc, 8'h00);
      issue(14'h38ff);
      check(acc, 8'hff);
      check(8'(zf), 8'h00);
      issue(14'h2000);
      check(8'(done), 8'h00);
      // leave a skip pending, then reset in mid-run
      issue(14'h0ffe);
      check({we, skip, 6'h00}, 8'hc0);
      check(acc, 8'hff);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1;
      check(acc, 8'h00);
      check({we, skip, zf, done, 4'h0}, 8'h00);
      issue(14'h3142);
      check(acc, 8'h42);
      complete_run();
   end
endmodule : incskip_or_literal_exec_bench
